/* rtl/slcid_top.sv */
// Link control and link protocol identity registers of a serial-wire debug port
`timescale 1ns/1ps

module slcid_top #(
   parameter logic       SERIAL_VARIANT = 1'b1,   // 1: serial_wire_port_variant
   parameter logic       ARCH_V2        = 1'b1,   // 1: port_architecture_v2
   parameter logic       TURN_VARIABLE  = 1'b1,   // 1: turnaround period may be changed
   parameter logic [3:0] INSTANCE_NUM   = 4'h0    // Arbitrary default, unique per board
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Link side (probe-driven clock, line reset from packet logic)
   input  wire logic        link_clk_i,
   input  wire logic        line_reset_i,
   // Port register access from the packet layer
   input  wire logic        acc_valid_i,
   input  wire logic        acc_write_i,
   input  wire logic [3:0]  acc_addr_i,
   input  wire logic [3:0]  port_bank_select_i,
   input  wire logic [31:0] acc_wdata_i,
   output logic             acc_hit_o,
   output logic             rdata_valid_o,
   output logic [31:0]      rdata_o,
   output logic             prot_err_o,
   // Turnaround sequencing
   input  wire logic        turn_start_i,
   output logic             turn_active_o,
   output logic             turn_done_o,
   output logic [1:0]       turnaround_period_sel_o
);
   import slcid_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      slcid_state_t st;
      logic [1:0]   turn_sel;   // turnaround_period_sel
      logic [2:0]   turn_cnt;   // Bit periods already spent tristated
      logic [31:0]  rdata;
      logic         rvalid;
      logic         hit;
      logic         perr;
      logic         tdone;
   } slcid_regs_t;

   slcid_regs_t r_q;
   slcid_regs_t r_d;

   logic        link_rise;
   logic        sel_ctrl;
   logic        sel_ident;
   logic        ident_present;
   logic [31:0] ctrl_word;
   logic [31:0] ident_word;
   logic [31:0] rd_word;
   logic        ctrl_wr;
   logic [1:0]  wr_turn_sel;
   logic        wr_turn_bad;

   // ----------------------------------------------------------------
   // Link clock sampling
   // ----------------------------------------------------------------
   // A rise shows two clocks after the pin edge, so the link clock
   // must stay well below a third of clk_i or edges merge
   slcid_edge_sync u_link_sync (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .link_clk_i (link_clk_i),
      .level_o    (),
      .rise_o     (link_rise)
   );

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Both registers share one offset; the bank select tells them apart
   assign sel_ctrl  = (acc_addr_i == SLCID_OFS_LINK)
                      && (port_bank_select_i == SLCID_BANK_CTRL);
   assign sel_ident = (acc_addr_i == SLCID_OFS_LINK)
                      && (port_bank_select_i == SLCID_BANK_IDENT);

   // Identity only exists on a serial v2 port; elsewhere it is reserved
   assign ident_present = SERIAL_VARIANT && ARCH_V2;

   // ----------------------------------------------------------------
   // Read views
   // ----------------------------------------------------------------
   // Spare bits fixed; scan-chain variant shows all zero
   always_comb begin
      ctrl_word = SLCID_WORD_ZERO;
      if (SERIAL_VARIANT) begin
         ctrl_word[SLCID_TURN_MSB:SLCID_TURN_LSB] = r_q.turn_sel;
         ctrl_word[SLCID_CTRL_ONE_BIT]            = 1'b1;
      end
   end

   // Identity word, fixed content, bits 27:4 stay zero
   always_comb begin
      ident_word = SLCID_WORD_ZERO;
      if (ident_present) begin
         ident_word[SLCID_INST_MSB:SLCID_INST_LSB] = INSTANCE_NUM;
         ident_word[SLCID_PVER_MSB:SLCID_PVER_LSB] = SLCID_PVER_V2_MDROP;
      end
   end

   // ----------------------------------------------------------------
   // Access qualifiers
   // ----------------------------------------------------------------
   // Only the serial variant has a writable control; identity never is
   assign ctrl_wr     = acc_valid_i && acc_write_i && sel_ctrl && SERIAL_VARIANT;
   assign wr_turn_sel = acc_wdata_i[SLCID_TURN_MSB:SLCID_TURN_LSB];
   // A fixed port cannot honour a longer turnaround, so it refuses loudly
   assign wr_turn_bad = !TURN_VARIABLE && (wr_turn_sel != SLCID_TURN_RESET);

   // Read word picked ahead of the flop; unmapped offsets answer zero
   always_comb begin
      rd_word = SLCID_WORD_ZERO;
      if (sel_ctrl) begin
         rd_word = ctrl_word;
      end else if (sel_ident) begin
         rd_word = ident_word;
      end
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      r_d        = r_q;
      r_d.rvalid = 1'b0;
      r_d.hit    = 1'b0;
      r_d.perr   = 1'b0;
      r_d.tdone  = 1'b0;

      // Register access: answers one cycle later from flops
      if (acc_valid_i) begin
         r_d.hit = sel_ctrl || sel_ident;
         if (!acc_write_i) begin
            r_d.rvalid = 1'b1;
            r_d.rdata  = rd_word;
         end
      end
      // Only the period field is writable; spare bits ignored
      if (ctrl_wr && TURN_VARIABLE) begin
         r_d.turn_sel = wr_turn_sel;
      end
      if (ctrl_wr && wr_turn_bad) begin
         r_d.perr = 1'b1;
      end

      // Turnaround sequencer: sel+1 link clock rising edges tristated
      unique case (r_q.st)
         SLCID_IDLE: begin
            if (turn_start_i) begin
               r_d.st       = SLCID_TURN;
               r_d.turn_cnt = SLCID_TURN_CNT_ZERO;
            end
         end
         SLCID_TURN: begin
            if (link_rise) begin
               if (r_q.turn_cnt == {1'b0, r_q.turn_sel}) begin
                  r_d.st    = SLCID_IDLE;
                  r_d.tdone = 1'b1;
               end else begin
                  r_d.turn_cnt = r_q.turn_cnt + 3'h1;
               end
            end
         end
         default: begin
            // Illegal one-hot code: recover to idle
            r_d.st = SLCID_IDLE;
         end
      endcase

      // Line reset wins over a same-cycle write and ends any turnaround
      if (line_reset_i) begin
         r_d.turn_sel = SLCID_TURN_RESET;
         r_d.st       = SLCID_IDLE;
         r_d.turn_cnt = SLCID_TURN_CNT_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Power-up reset: single bit period turnaround
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         r_q          <= '0;
         r_q.st       <= SLCID_IDLE;
         r_q.turn_sel <= SLCID_TURN_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign acc_hit_o               = r_q.hit;
   assign rdata_valid_o           = r_q.rvalid;
   assign rdata_o                 = r_q.rdata;
   assign prot_err_o              = r_q.perr;
   assign turn_active_o           = (r_q.st == SLCID_TURN);
   assign turn_done_o             = r_q.tdone;
   assign turnaround_period_sel_o = r_q.turn_sel;

endmodule : slcid_top

/* rtl/slcid_pkg.sv */
// Package: offsets, field layout and encodings of the link control/identity pair
package slcid_pkg;

   // ----------------------------------------------------------------
   // Register map (byte offset within the port map, bank select)
   // ----------------------------------------------------------------
   localparam logic [3:0] SLCID_OFS_LINK       = 4'h4;   // Shared offset of both registers
   localparam logic [3:0] SLCID_BANK_CTRL      = 4'h1;   // Bank of link_turnaround_control
   localparam logic [3:0] SLCID_BANK_IDENT     = 4'h3;   // Bank of link_protocol_identity

   // ----------------------------------------------------------------
   // link_turnaround_control fields
   // ----------------------------------------------------------------
   localparam int         SLCID_TURN_LSB       = 8;      // turnaround_period_sel low bit
   localparam int         SLCID_TURN_MSB       = 9;      // turnaround_period_sel high bit
   localparam int         SLCID_CTRL_ONE_BIT   = 6;      // Reads as one
   localparam logic [1:0] SLCID_TURN_RESET     = 2'h0;   // One bit period
   localparam logic [2:0] SLCID_TURN_CNT_ZERO  = 3'h0;

   // ----------------------------------------------------------------
   // link_protocol_identity fields
   // ----------------------------------------------------------------
   localparam int         SLCID_INST_LSB       = 28;     // multidrop_instance_number
   localparam int         SLCID_INST_MSB       = 31;
   localparam int         SLCID_PVER_LSB       = 0;      // wire_protocol_version
   localparam int         SLCID_PVER_MSB       = 3;
   localparam logic [3:0] SLCID_PVER_V2_MDROP  = 4'h1;   // Version 2 with multidrop
   localparam logic [31:0] SLCID_WORD_ZERO     = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Turnaround sequencer states (one-hot)
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SLCID_IDLE = 2'b01,
      SLCID_TURN = 2'b10
   } slcid_state_t;

endpackage : slcid_pkg

/* rtl/slcid_edge_sync.sv */
// Two-flop synchroniser of the probe's link clock with rising-edge detect
`timescale 1ns/1ps
module slcid_edge_sync (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // Asynchronous link clock pin
   input  wire logic link_clk_i,
   // Synchronised level and one-cycle rising-edge pulse
   output logic      level_o,
   output logic      rise_o
);

   typedef struct packed {
      logic meta;   // First stage, read only by the second
      logic sync;
      logic prev;
   } slcid_sync_t;

   slcid_sync_t s_q;
   slcid_sync_t s_d;

   // Shift chain; edge detect looks only past the first stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = link_clk_i;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   // Synchronous reset, constants only
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_o = s_q.sync;
   assign rise_o  = s_q.sync & ~s_q.prev;

endmodule : slcid_edge_sync

/* tb/slcid_monitor.sv */
// Port checker of the link control and identity pair
`timescale 1ns/1ps
module slcid_monitor #(
   parameter logic       SERIAL_VARIANT = 1'b1,
   parameter logic       ARCH_V2        = 1'b1,
   parameter logic       TURN_VARIABLE  = 1'b1,
   parameter logic [3:0] INSTANCE_NUM   = 4'h0
) (
   // Clock, reset and requests
   input wire logic        clk_i, nrst_i, line_reset_i, acc_valid_i, acc_write_i, turn_start_i,
   input wire logic [3:0]  acc_addr_i, port_bank_select_i,
   input wire logic [31:0] acc_wdata_i,
   // Answers
   input wire logic        acc_hit_o, rdata_valid_o, turn_active_o, turn_done_o,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0]  turnaround_period_sel_o
);
   // -----------------------------------------------------------------
   // Decodes and sequences
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic rd, cw, ir;
   // Offset 0x4 selects control in bank 1, identity in bank 3
   assign rd = acc_valid_i && !acc_write_i;
   assign cw = acc_valid_i && acc_addr_i == 4'h4 && port_bank_select_i == 4'h1;
   assign ir = acc_valid_i && acc_addr_i == 4'h4 && port_bank_select_i == 4'h3;
   sequence s_start;
      turn_start_i && !turn_active_o && !line_reset_i;
   endsequence
   sequence s_end;
      turn_done_o && !turn_active_o;
   endsequence
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_read_answered: assert property (rd |=> rdata_valid_o)
      else $error("read not answered");
   a_ctrl_hit: assert property (cw |=> acc_hit_o)
      else $error("control access missed");
   a_ident_hit: assert property (ir |=> acc_hit_o)
      else $error("identity access missed");
   a_ident_word: assert property (ir && !acc_write_i |=> rdata_o == ((SERIAL_VARIANT && ARCH_V2) ? {INSTANCE_NUM, 24'h0, 4'h1} : 32'h0))
      else $error("identity word wrong");
   a_ctrl_word: assert property (cw && !acc_write_i |=> rdata_o == (SERIAL_VARIANT ? {22'h0, $past(turnaround_period_sel_o), 8'h40} : 32'h0))
      else $error("control word wrong");
   a_ctrl_write: assert property (cw && acc_write_i && !line_reset_i |=> turnaround_period_sel_o == ((SERIAL_VARIANT && TURN_VARIABLE) ? $past(acc_wdata_i[9:8]) : 2'h0))
      else $error("turnaround write lost");
   a_line_reset: assert property (line_reset_i |=> turnaround_period_sel_o == 2'h0 && !turn_active_o)
      else $error("line reset ignored");
   a_turn_start: assert property (s_start |=> turn_active_o)
      else $error("turnaround not started");
   a_turn_bounded: assert property ($rose(turn_active_o) |-> ##[1:100] !turn_active_o)
      else $error("turnaround too long");
   a_done_pulse: assert property (turn_done_o |-> $past(turn_active_o) ##0 s_end ##1 !turn_done_o)
      else $error("done pulse malformed");
endmodule : slcid_monitor

bind slcid_top slcid_monitor #(.SERIAL_VARIANT(SERIAL_VARIANT), .ARCH_V2(ARCH_V2),
   .TURN_VARIABLE(TURN_VARIABLE), .INSTANCE_NUM(INSTANCE_NUM)) mon_u (.*);

/* tb/slcid_probe_model.sv */
// Probe model: makes the link clock only during commanded bursts
`timescale 1ns/1ps
module slcid_probe_model (
   // Link clock to the port
   output logic link_clk_o
);
   // Clock rests low between bursts, as a probe's does
   initial link_clk_o = 1'b0;
   // One rising edge per 48 ns bit period
   task automatic bits(input int n);
      for (int k = 0; k < n; k++) begin
         #24 link_clk_o = 1'b1;
         #24 link_clk_o = 1'b0;
      end
   endtask : bits
endmodule : slcid_probe_model

/* tb/slcid_top_test.sv */
// Self-checking bench of the link control and identity pair
`timescale 1ns/1ps
module slcid_top_test;
   import slcid_pkg::*;
   typedef struct {logic w; logic [3:0] bank, addr; logic [31:0] wd, rd; logic hit;} slcid_row_t;
   localparam logic [3:0] INST = 4'ha;   // Arbitrary instance number
   logic clk_i = 1'b0, nrst_i = 1'b0, line_reset_i = 1'b0, acc_valid_i = 1'b0;
   logic acc_write_i = 1'b0, turn_start_i = 1'b0, link_clk_i;
   logic acc_hit_o, rdata_valid_o, prot_err_o, turn_active_o, turn_done_o;
   logic [3:0]  acc_addr_i = 4'h0, port_bank_select_i = 4'h0;
   logic [31:0] acc_wdata_i = 32'h0, rdata_o, id;
   logic [1:0]  turnaround_period_sel_o;
   logic        fix_perr, scan_hit;
   logic [1:0]  fix_sel;
   logic [31:0] fix_rdata, scan_rdata;
   int fail_count = 0, check_count = 0, dones = 0;
   slcid_row_t rows[12];
   // ------------------------------------------------------------
   // Clock, design, probe, helpers
   // ------------------------------------------------------------
   always #2.5 clk_i = ~clk_i;
   slcid_top #(.INSTANCE_NUM(INST)) dut_u (.*);
   // Fixed-turnaround and scan-chain builds see the same stimulus
   slcid_top #(.TURN_VARIABLE(1'b0)) fix_u (.clk_i(clk_i), .nrst_i(nrst_i),
      .link_clk_i(link_clk_i), .line_reset_i(line_reset_i),
      .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
      .port_bank_select_i(port_bank_select_i), .acc_wdata_i(acc_wdata_i), .acc_hit_o(),
      .rdata_valid_o(), .rdata_o(fix_rdata), .prot_err_o(fix_perr),
      .turn_start_i(turn_start_i), .turn_active_o(), .turn_done_o(),
      .turnaround_period_sel_o(fix_sel));
   slcid_top #(.SERIAL_VARIANT(1'b0)) scan_u (.clk_i(clk_i), .nrst_i(nrst_i),
      .link_clk_i(link_clk_i), .line_reset_i(line_reset_i),
      .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
      .port_bank_select_i(port_bank_select_i), .acc_wdata_i(acc_wdata_i),
      .acc_hit_o(scan_hit), .rdata_valid_o(), .rdata_o(scan_rdata), .prot_err_o(),
      .turn_start_i(turn_start_i), .turn_active_o(), .turn_done_o(),
      .turnaround_period_sel_o());
   slcid_probe_model probe_u (.link_clk_o(link_clk_i));
   // Done pulses last one cycle, so count them as they pass
   always @(posedge clk_i) if (turn_done_o === 1'b1) dones++;
   task automatic check(input logic ok, input string what);
      check_count++;
      if (!ok) begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check
   // One idle edge keeps back-to-back calls apart, then one access
   task automatic access(input logic w, input logic [3:0] bank, addr, input logic [31:0] wd);
      @(negedge clk_i);
      acc_valid_i = 1'b1;
      acc_write_i = w;
      port_bank_select_i = bank;
      acc_addr_i = addr;
      acc_wdata_i = wd;
      @(negedge clk_i);
      acc_valid_i = 1'b0;
   endtask : access
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      #50us;
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      id = {INST, 24'h0, SLCID_PVER_V2_MDROP};
      rows = '{'{1'h1, 4'h1, 4'h4, 32'hffff_feff, 32'h0, 1'h1},
         '{1'h0, 4'h1, 4'h4, 32'h0, 32'h240, 1'h1}, '{1'h1, 4'h1, 4'h4, 32'h100, 32'h0, 1'h1},
         '{1'h0, 4'h1, 4'h4, 32'h0, 32'h140, 1'h1}, '{1'h0, 4'h3, 4'h4, 32'h0, id, 1'h1},
         '{1'h1, 4'h3, 4'h4, 32'hffff_ffff, 32'h0, 1'h1}, '{1'h0, 4'h3, 4'h4, 32'h0, id, 1'h1},
         '{1'h0, 4'h0, 4'h4, 32'h0, 32'h0, 1'h0}, '{1'h0, 4'h2, 4'h4, 32'h0, 32'h0, 1'h0},
         '{1'h0, 4'h1, 4'h0, 32'h0, 32'h0, 1'h0}, '{1'h1, 4'h2, 4'h4, 32'h300, 32'h0, 1'h0},
         '{1'h0, 4'h1, 4'h4, 32'h0, 32'h140, 1'h1}};
      repeat (10) @(negedge clk_i);
      nrst_i = 1'b1;
      check(turnaround_period_sel_o === 2'h0, "reset field");
      foreach (rows[i]) begin
         access(rows[i].w, rows[i].bank, rows[i].addr, rows[i].wd);
         check(acc_hit_o === rows[i].hit && rdata_valid_o === !rows[i].w, "status");
         if (!rows[i].w) check(rdata_o === rows[i].rd, "read word");
      end
      // Line reset must beat a write in the same cycle
      line_reset_i = 1'b1;
      access(1'b1, 4'h1, 4'h4, 32'h300);
      line_reset_i = 1'b0;
      check(turnaround_period_sel_o === 2'h0, "line reset");
      // Every code: sel edges must not finish, one more must
      for (int s = 0; s < 4; s++) begin
         access(1'b1, 4'h1, 4'h4, 32'(s) << 8);
         dones = 0;
         turn_start_i = 1'b1;
         @(negedge clk_i);
         turn_start_i = 1'b0;
         probe_u.bits(s);
         repeat (6) @(negedge clk_i);
         check(turn_active_o === 1'b1 && dones == 0, "early end");
         probe_u.bits(1);
         repeat (4) @(negedge clk_i);
         check(turn_active_o === 1'b0 && dones == 1, "length");
      end
      // Abort in mid-turnaround: no done, field cleared
      turn_start_i = 1'b1;
      @(negedge clk_i);
      turn_start_i = 1'b0;
      line_reset_i = 1'b1;
      dones = 0;
      @(negedge clk_i);
      line_reset_i = 1'b0;
      probe_u.bits(4);
      @(negedge clk_i);
      check(turn_active_o === 1'b0 && dones == 0 && turnaround_period_sel_o === 2'h0, "abort");
      check(prot_err_o === 1'b0, "error flag");
      // Variant builds: fixed port refuses a longer turnaround, scan-chain port is blank
      access(1'b1, 4'h1, 4'h4, 32'h300);
      check(fix_perr === 1'b1 && fix_sel === 2'h0, "fixed write");
      check(turnaround_period_sel_o === 2'h3, "variable write");
      access(1'b0, 4'h1, 4'h4, 32'h0);
      check(rdata_o === 32'h340 && fix_rdata === 32'h40, "control view");
      check(scan_rdata === 32'h0, "scan control");
      access(1'b0, 4'h3, 4'h4, 32'h0);
      check(scan_hit === 1'b1 && scan_rdata === 32'h0, "scan identity");
      check(fix_perr === 1'b0 && prot_err_o === 1'b0, "error pulse");
      tally_and_finish();
   end
endmodule : slcid_top_test
